// >>> design/sqf_host.sv
/*
  Host controller for a serial quad flash: drives chip select, the serial
  clock and four data lines, sequences opcode, address, mode bits, dummy
  clocks and data, and polls status after program and erase.
  Assumes the device is powered when rst_n releases; the serial clock is
  made here by a divider, so the link has no domain of its own.
*/
// Operation
// - Four dummy clocks keep the link at 84 MHz or less, six allow more.
// - Alternating mode bits enter continuous read; later quad reads skip the opcode.
// - Without continuous read the host sends all-ones mode bits.
// - Host drives the data lines during both mode-bit clocks.
// - Plain read 03 is single-line only, no dummy, clock at most 33 MHz.
// - Fast read 0B in both modes, quad link limited to 84 MHz.
// - Chip select stays high 300 us after power before first selection.
// - Write-type commands are refused with an error until the power-up write delay ends.
// - Busy timeouts: status write 40 ms, page 3 ms, sector 200 ms.
// - Busy timeouts: half block 1000 ms, block 2000 ms, chip 10 s.
`timescale 1ns/100ps
`default_nettype none

module sqf_host #(
  parameter int unsigned SUPPLY_CYC     = sqf_pkg::SUPPLY_TO_SELECT_CYC,
  parameter int unsigned POWERUP_CYC    = sqf_pkg::POWERUP_WRITE_CYC,
  parameter int unsigned STATUS_TMO     = sqf_pkg::STATUS_WRITE_CYC,
  parameter int unsigned PAGE_TMO       = sqf_pkg::PAGE_WRITE_CYC,
  parameter int unsigned SECTOR_TMO     = sqf_pkg::SECTOR_WIPE_CYC,
  parameter int unsigned HALF_BLOCK_TMO = sqf_pkg::HALF_BLOCK_WIPE_CYC,
  parameter int unsigned BLOCK_TMO      = sqf_pkg::BLOCK_WIPE_CYC,
  parameter int unsigned CHIP_TMO       = sqf_pkg::CHIP_WIPE_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        req_valid,
  output var  logic        req_ready,
  input  wire logic [7:0]  req_cmd,
  input  wire logic [23:0] req_addr,
  input  wire logic [8:0]  req_len,
  input  wire logic        req_quad_link,
  input  wire logic        req_dummy_long,
  input  wire logic        req_cont_read,
  input  wire logic        req_part_id_first,
  input  wire logic [7:0]  wr_data,
  input  wire logic        wr_valid,
  output var  logic        wr_ready,
  output var  logic [7:0]  rd_data,
  output var  logic        rd_valid,
  output var  logic        done,
  output var  logic        err,
  output var  logic        cont_mode,
  output var  logic        write_allowed,
  output var  logic        sclk,
  output var  logic        cs_n,
  output var  logic [3:0]  io_o,
  output var  logic [3:0]  io_oe_n,
  input  wire logic [3:0]  io_i
);
  import sqf_pkg::*;

  typedef struct packed {
    sqf_state_t  st;
    sqf_phase_t  ph;
    logic        ready, wr_ready, rd_valid, done, err, sclk, cs_n;
    logic [3:0]  io_o, io_oe_n;
    logic [7:0]  rd_data, op, mode;
    logic [23:0] addr;
    logic [31:0] sh;
    logic [2:0]  w, div;
    logic [5:0]  cnt;
    logic [8:0]  len;
    logic [3:0]  dummy, gap;
    logic        ql, quad_tx, f_op, f_addr, f_mode, wr_dir, is_wr;
    logic        cont, exit_pend, polling, busy_seen, pw_ok;
    logic [31:0] boot_cnt, pw_cnt, tmo;
  } sqf_regs_t;

  localparam sqf_regs_t RESET_VAL = '{st: ST_BOOT, ph: PH_END, cs_n: 1'b1,
    io_o: 4'hF, io_oe_n: 4'hF, boot_cnt: SUPPLY_CYC, pw_cnt: POWERUP_CYC,
    default: '0};

  sqf_regs_t  s, n;
  sqf_phase_t p_nx;
  logic [31:0] sh_nx;
  logic        rst_sync_n;
  logic [3:0]  io_s;

  sqf_sync #(.W(1)) u_rst_sync (.clk(clk), .rst_n(rst_n), .d(1'b1), .q(rst_sync_n));
  sqf_sync #(.W(4)) u_io_sync  (.clk(clk), .rst_n(rst_sync_n), .d(io_i), .q(io_s));

  function automatic logic known(input logic [7:0] op);
    case (op)
      OP_WRITE_UNLOCK, OP_WRITE_LOCK:                  known = 1'b1;
      OP_STATUS_READ, OP_STATUS_WRITE:                 known = 1'b1;
      OP_IDENT_READ, OP_READ, OP_FAST_READ, OP_DUAL_ADDR_READ,
      OP_QUAD_ADDR_READ, OP_MAKER_PART_ID:             known = 1'b1;
      OP_PAGE_WRITE, OP_QUAD_PAGE_WRITE:               known = 1'b1;
      OP_SECTOR_WIPE, OP_HALF_BLOCK_WIPE, OP_BLOCK_WIPE,
      OP_CHIP_WIPE_A, OP_CHIP_WIPE_B:                  known = 1'b1;
      OP_SLEEP, OP_WAKE_SIGNATURE:                     known = 1'b1;
      OP_SECURE_REG_READ, OP_SECURE_REG_WRITE:         known = 1'b1;
      default:                                         known = 1'b0;
    endcase
  endfunction

  // Commands the quad link cannot carry
  function automatic logic single_only(input logic [7:0] op);
    single_only = op inside {OP_IDENT_READ, OP_MAKER_PART_ID, OP_READ,
                             OP_DUAL_ADDR_READ, OP_QUAD_PAGE_WRITE};
  endfunction

  function automatic logic is_write(input logic [7:0] op);
    is_write = op inside {OP_STATUS_WRITE, OP_PAGE_WRITE, OP_QUAD_PAGE_WRITE,
                          OP_SECTOR_WIPE, OP_HALF_BLOCK_WIPE, OP_BLOCK_WIPE,
                          OP_CHIP_WIPE_A, OP_CHIP_WIPE_B, OP_SECURE_REG_WRITE};
  endfunction

  function automatic logic [31:0] tmo_for(input logic [7:0] op);
    case (op)
      OP_PAGE_WRITE, OP_QUAD_PAGE_WRITE: tmo_for = PAGE_TMO;
      OP_SECTOR_WIPE:                    tmo_for = SECTOR_TMO;
      OP_HALF_BLOCK_WIPE:                tmo_for = HALF_BLOCK_TMO;
      OP_BLOCK_WIPE:                     tmo_for = BLOCK_TMO;
      OP_CHIP_WIPE_A, OP_CHIP_WIPE_B:    tmo_for = CHIP_TMO;
      default:                           tmo_for = STATUS_TMO;
    endcase
  endfunction

  function automatic logic [2:0] wid(input sqf_regs_t r, input sqf_phase_t p);
    if (r.ql || p == PH_EXIT) wid = 3'd4;
    else if (p == PH_OP) wid = 3'd1;
    else if (r.op == OP_QUAD_ADDR_READ || r.op == OP_QUAD_PAGE_WRITE) wid = 3'd4;
    else if (r.op == OP_DUAL_ADDR_READ) wid = 3'd2;
    else wid = 3'd1;
  endfunction

  function automatic logic [5:0] clocks(input logic [5:0] bits, input logic [2:0] w);
    case (w)
      3'd4:    clocks = bits >> 2;
      3'd2:    clocks = bits >> 1;
      default: clocks = bits;
    endcase
  endfunction

  function automatic sqf_phase_t nxt(input sqf_regs_t r, input sqf_phase_t p);
    if (p == PH_EXIT && r.exit_pend) nxt = PH_END;
    else if (p < PH_OP && r.f_op) nxt = PH_OP;
    else if (p < PH_ADDR && r.f_addr) nxt = PH_ADDR;
    else if (p < PH_MODE && r.f_mode) nxt = PH_MODE;
    else if (p < PH_DUMMY && r.dummy != 4'h0) nxt = PH_DUMMY;
    else if (p < PH_WR && r.wr_dir && r.len != 9'h000) nxt = PH_WR;
    else if (p < PH_RD && !r.wr_dir && r.len != 9'h000) nxt = PH_RD;
    else nxt = PH_END;
  endfunction

  function automatic sqf_regs_t enter(input sqf_regs_t r, input sqf_phase_t p);
    sqf_regs_t o;
    o = r;
    o.ph = p;
    o.w = wid(r, p);
    o.wr_ready = (p == PH_WR);
    case (p)
      PH_EXIT:  begin o.cnt = EXIT_CLOCKS; o.sh = '1; end
      PH_OP:    begin o.cnt = clocks(6'h08, o.w); o.sh = {r.op, 24'h000000}; end
      PH_ADDR:  begin o.cnt = clocks(6'h18, o.w); o.sh = {r.addr, 8'h00}; end
      PH_MODE:  begin o.cnt = clocks(6'h08, o.w); o.sh = {r.mode, 24'h000000}; end
      PH_DUMMY: o.cnt = {2'b00, r.dummy};
      default:  o.cnt = clocks(6'h08, o.w);
    endcase
    return o;
  endfunction

  function automatic sqf_regs_t begin_xfer(input sqf_regs_t r, input sqf_phase_t p);
    sqf_regs_t o;
    o = enter(r, p);
    o.st = ST_XFER;
    o.cs_n = 1'b0;
    o.sclk = 1'b0;
    o.div = (r.op == OP_READ) ? 3'(SLOW_HALF_CYC - 1) : 3'(FAST_HALF_CYC - 1);
    return o;
  endfunction

  function automatic sqf_regs_t setup(input sqf_regs_t r, input logic [7:0] op,
                                      input logic [23:0] addr, input logic [8:0] len,
                                      input logic ql, input logic dl, input logic cr,
                                      input logic pid);
    sqf_regs_t o;
    logic      quad;
    o = r;
    quad = (op == OP_QUAD_ADDR_READ);
    o.op = op;
    o.ql = ql;
    o.len = len;
    o.is_wr = is_write(op);
    o.wr_dir = op inside {OP_PAGE_WRITE, OP_QUAD_PAGE_WRITE, OP_STATUS_WRITE,
                          OP_SECURE_REG_WRITE};
    o.f_op = !(r.cont && quad);
    o.f_addr = op inside {OP_READ, OP_FAST_READ, OP_DUAL_ADDR_READ, OP_QUAD_ADDR_READ,
                          OP_PAGE_WRITE, OP_QUAD_PAGE_WRITE, OP_SECTOR_WIPE,
                          OP_HALF_BLOCK_WIPE, OP_BLOCK_WIPE, OP_MAKER_PART_ID}
               || (op == OP_WAKE_SIGNATURE && len != 9'h000);
    if (op == OP_MAKER_PART_ID)
      o.addr = pid ? ID_PART_FIRST_ADDR : ID_MAKER_FIRST_ADDR;
    else
      o.addr = (op == OP_WAKE_SIGNATURE) ? 24'h000000 : addr;
    o.f_mode = quad;
    o.mode = cr ? MODE_ENTER : MODE_IDLE;
    if (quad)
      o.cont = cr;
    if (quad || (op == OP_FAST_READ && ql))
      o.dummy = dl ? DUMMY_LONG : DUMMY_SHORT;
    else if (op == OP_FAST_READ)
      o.dummy = DUMMY_FAST_SPI;
    else if (op == OP_DUAL_ADDR_READ)
      o.dummy = DUMMY_DUAL;
    else
      o.dummy = 4'h0;
    o.quad_tx = ql || quad || op == OP_QUAD_PAGE_WRITE;
    return o;
  endfunction

  always_comb begin
    n = s;
    p_nx = nxt(s, s.ph);
    sh_nx = s.sh << s.w;
    n.rd_valid = 1'b0;
    n.done = 1'b0;
    n.err = 1'b0;
    if (s.pw_cnt != 32'h0) n.pw_cnt = s.pw_cnt - 32'h1;
    else n.pw_ok = 1'b1;
    if (s.tmo != 32'h0) n.tmo = s.tmo - 32'h1;
    case (s.st)
      ST_BOOT: begin
        if (s.boot_cnt == 32'h0) n.st = ST_IDLE;
        else n.boot_cnt = s.boot_cnt - 32'h1;
      end
      ST_IDLE: begin
        if (s.ready && req_valid) begin
          n.ready = 1'b0;
          if (!known(req_cmd) || (req_quad_link && single_only(req_cmd))) begin
            n.err = 1'b1;
            n.done = 1'b1;
          end else if (is_write(req_cmd) && !s.pw_ok) begin
            n.err = 1'b1;
            n.done = 1'b1;
          end else begin
            n = setup(n, req_cmd, req_addr, req_len, req_quad_link, req_dummy_long,
                      req_cont_read, req_part_id_first);
            n.polling = 1'b0;
            if (s.cont && req_cmd != OP_QUAD_ADDR_READ) begin
              n.exit_pend = 1'b1;
              n.cont = 1'b0;
              n = begin_xfer(n, PH_EXIT);
            end else begin
              n = begin_xfer(n, nxt(n, PH_EXIT));
            end
          end
        end else begin
          n.ready = 1'b1;
        end
      end
      ST_XFER: begin
        if (s.wr_ready) begin
          // Link clock simply pauses while write data is late
          if (wr_valid) begin
            n.sh[31:24] = wr_data;
            n.wr_ready = 1'b0;
          end
        end else if (s.div != 3'h0) begin
          n.div = s.div - 3'h1;
        end else begin
          n.div = (s.op == OP_READ) ? 3'(SLOW_HALF_CYC - 1) : 3'(FAST_HALF_CYC - 1);
          n.sclk = !s.sclk;
          if (s.sclk) begin
            // Falling edge: sample read data, present the next bits
            if (s.ph == PH_RD) begin
              case (s.w)
                3'd4:    n.sh = {s.sh[27:0], io_s};
                3'd2:    n.sh = {s.sh[29:0], io_s[1:0]};
                default: n.sh = {s.sh[30:0], io_s[1]};
              endcase
            end else begin
              n.sh = sh_nx;
            end
            if (s.cnt != 6'h01) begin
              n.cnt = s.cnt - 6'h01;
            end else begin
              if (s.ph == PH_RD && s.polling)
                n.busy_seen = n.sh[STATUS_BUSY_BIT];
              else if (s.ph == PH_RD) begin
                n.rd_data = n.sh[7:0];
                n.rd_valid = 1'b1;
              end
              if ((s.ph == PH_RD || s.ph == PH_WR) && s.len != 9'h001) begin
                n.len = s.len - 9'h001;
                n.cnt = clocks(6'h08, s.w);
                n.wr_ready = (s.ph == PH_WR);
              end else if (p_nx == PH_END) begin
                n.st = ST_GAP;
                n.gap = 4'(DESELECT_CYC + CS_HOLD_CYC - 1);
              end else begin
                n = enter(n, p_nx);
              end
            end
          end
        end
      end
      ST_GAP: begin
        // Select held briefly after the last fall, then deselect time
        n.gap = s.gap - 4'h1;
        if (s.gap <= 4'(DESELECT_CYC)) n.cs_n = 1'b1;
        if (s.gap == 4'h0) begin
          n.gap = 4'h0;
          if (s.exit_pend) begin
            n.exit_pend = 1'b0;
            n = begin_xfer(n, nxt(n, PH_EXIT));
          end else if (!s.polling && s.is_wr) begin
            n.tmo = tmo_for(s.op);
            n.polling = 1'b1;
            n = setup(n, OP_STATUS_READ, 24'h000000, 9'h001, s.ql, 1'b0, 1'b0, 1'b0);
            n = begin_xfer(n, nxt(n, PH_EXIT));
          end else if (s.polling && s.busy_seen && s.tmo != 32'h0) begin
            n = begin_xfer(n, nxt(n, PH_EXIT));
          end else begin
            n.st = ST_IDLE;
            n.done = 1'b1;
            n.err = s.polling && s.busy_seen;
            n.polling = 1'b0;
          end
        end
      end
      default: n = RESET_VAL;
    endcase
    n.io_o = 4'hF;
    n.io_oe_n = 4'hF;
    if (n.st == ST_XFER) begin
      if (n.ph inside {PH_EXIT, PH_OP, PH_ADDR, PH_MODE, PH_WR}) begin
        case (n.w)
          3'd4: begin
            n.io_o = n.sh[31:28];
            n.io_oe_n = 4'h0;
          end
          3'd2: begin
            n.io_o[1:0] = n.sh[31:30];
            n.io_oe_n[1:0] = 2'b00;
          end
          default: begin
            n.io_o[0] = n.sh[31];
            n.io_oe_n[0] = 1'b0;
          end
        endcase
      end
      // Protect and hold lines parked high on narrow transfers
      if (!n.quad_tx) begin
        n.io_o[3:2] = 2'b11;
        n.io_oe_n[3:2] = 2'b00;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) s <= RESET_VAL;
    else s <= n;
  end

  assign req_ready     = s.ready;
  assign wr_ready      = s.wr_ready;
  assign rd_data       = s.rd_data;
  assign rd_valid      = s.rd_valid;
  assign done          = s.done;
  assign err           = s.err;
  assign cont_mode     = s.cont;
  assign write_allowed = s.pw_ok;
  assign sclk          = s.sclk;
  assign cs_n          = s.cs_n;
  assign io_o          = s.io_o;
  assign io_oe_n       = s.io_oe_n;

endmodule

`default_nettype wire

// >>> include/sqf_pkg.sv
/*
  Constants and types shared by the serial quad flash host controller:
  opcodes, mode-bit patterns, link timing and busy timeouts in cycles.
  Assumes a 250 MHz system clock; all counts are derived from that rate.
*/
package sqf_pkg;

  localparam int unsigned     CLK_MHZ = 250;
  localparam longint unsigned CLK_HZ  = 64'd250_000_000;
  localparam longint unsigned CLK_KHZ = CLK_HZ / 1000;

  // Opcodes
  localparam logic [7:0] OP_WRITE_UNLOCK    = 8'h06;
  localparam logic [7:0] OP_WRITE_LOCK      = 8'h04;
  localparam logic [7:0] OP_IDENT_READ      = 8'h9F;
  localparam logic [7:0] OP_STATUS_READ     = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE    = 8'h01;
  localparam logic [7:0] OP_READ            = 8'h03;
  localparam logic [7:0] OP_FAST_READ       = 8'h0B;
  localparam logic [7:0] OP_DUAL_ADDR_READ  = 8'hBB;
  localparam logic [7:0] OP_QUAD_ADDR_READ  = 8'hEB;
  localparam logic [7:0] OP_PAGE_WRITE      = 8'h02;
  localparam logic [7:0] OP_QUAD_PAGE_WRITE = 8'h38;
  localparam logic [7:0] OP_SECTOR_WIPE     = 8'h20;
  localparam logic [7:0] OP_HALF_BLOCK_WIPE = 8'h52;
  localparam logic [7:0] OP_BLOCK_WIPE      = 8'hD8;
  localparam logic [7:0] OP_CHIP_WIPE_A     = 8'h60;
  localparam logic [7:0] OP_CHIP_WIPE_B     = 8'hC7;
  localparam logic [7:0] OP_SLEEP           = 8'hB9;
  localparam logic [7:0] OP_WAKE_SIGNATURE  = 8'hAB;
  localparam logic [7:0] OP_MAKER_PART_ID   = 8'h90;
  localparam logic [7:0] OP_SECURE_REG_READ = 8'h2B;
  localparam logic [7:0] OP_SECURE_REG_WRITE = 8'h2F;

  // Mode bits and identification address
  localparam logic [7:0]  MODE_ENTER          = 8'hA5;
  localparam logic [7:0]  MODE_IDLE           = 8'hFF;
  localparam logic [23:0] ID_MAKER_FIRST_ADDR = 24'h000000;
  localparam logic [23:0] ID_PART_FIRST_ADDR  = 24'h000001;
  localparam int unsigned STATUS_BUSY_BIT     = 0;

  // Dummy clocks
  localparam logic [3:0] DUMMY_SHORT     = 4'h4;
  localparam logic [3:0] DUMMY_LONG      = 4'h6;
  localparam logic [3:0] DUMMY_FAST_SPI  = 4'h8;
  localparam logic [3:0] DUMMY_DUAL      = 4'h4;
  localparam logic [5:0] EXIT_CLOCKS     = 6'h08;

  // Link clock limits and derived half periods
  localparam int unsigned FAST_LIMIT_MHZ = 84;
  localparam int unsigned READ_LIMIT_MHZ = 33;
  localparam int unsigned SYNC_STAGES    = 2;
  // Extra cycle per half so read data survives the input synchroniser
  localparam int unsigned FAST_HALF_CYC  =
    (CLK_MHZ + 2 * FAST_LIMIT_MHZ - 1) / (2 * FAST_LIMIT_MHZ) + SYNC_STAGES - 1;
  localparam int unsigned SLOW_HALF_CYC  =
    (CLK_MHZ + 2 * READ_LIMIT_MHZ - 1) / (2 * READ_LIMIT_MHZ) + SYNC_STAGES - 1;
  localparam int unsigned DESELECT_NS    = 30;
  localparam int unsigned DESELECT_CYC   = (DESELECT_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CS_HOLD_NS     = 5;
  localparam int unsigned CS_HOLD_CYC    = (CS_HOLD_NS * CLK_MHZ + 999) / 1000;

  // Power-up and busy times
  localparam int unsigned SUPPLY_TO_SELECT_US  = 300;
  localparam int unsigned SUPPLY_TO_SELECT_CYC = SUPPLY_TO_SELECT_US * CLK_MHZ;
  localparam int unsigned POWERUP_WRITE_MS     = 10;
  localparam int unsigned POWERUP_WRITE_CYC    = 32'(POWERUP_WRITE_MS * CLK_KHZ);
  localparam int unsigned STATUS_WRITE_MS      = 40;
  localparam int unsigned STATUS_WRITE_CYC     = 32'(STATUS_WRITE_MS * CLK_KHZ);
  localparam int unsigned PAGE_WRITE_MS        = 3;
  localparam int unsigned PAGE_WRITE_CYC       = 32'(PAGE_WRITE_MS * CLK_KHZ);
  localparam int unsigned SECTOR_WIPE_MS       = 200;
  localparam int unsigned SECTOR_WIPE_CYC      = 32'(SECTOR_WIPE_MS * CLK_KHZ);
  localparam int unsigned HALF_BLOCK_WIPE_MS   = 1000;
  localparam int unsigned HALF_BLOCK_WIPE_CYC  = 32'(HALF_BLOCK_WIPE_MS * CLK_KHZ);
  localparam int unsigned BLOCK_WIPE_MS        = 2000;
  localparam int unsigned BLOCK_WIPE_CYC       = 32'(BLOCK_WIPE_MS * CLK_KHZ);
  localparam longint unsigned CHIP_WIPE_S      = 64'd10;
  localparam int unsigned CHIP_WIPE_CYC        = 32'(CHIP_WIPE_S * CLK_HZ);

  typedef enum logic [3:0] {
    ST_BOOT = 4'b0001,
    ST_IDLE = 4'b0010,
    ST_XFER = 4'b0100,
    ST_GAP  = 4'b1000
  } sqf_state_t;

  typedef enum logic [2:0] {
    PH_EXIT, PH_OP, PH_ADDR, PH_MODE, PH_DUMMY, PH_WR, PH_RD, PH_END
  } sqf_phase_t;

endpackage

// >>> design/sqf_sync.sv
/*
  Two flip-flop synchroniser, also used to release the reset.
  Assumes d is a level from another domain or a pin.
*/
`timescale 1ns/100ps
`default_nettype none

module sqf_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  // First stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

`default_nettype wire

// >>> dv/sqf_host_monitor.sv
/* Checker on the flash host ports.
   Assumes a bind to sqf_host and the single clk domain. */
`timescale 1ns/100ps
`default_nettype none
module sqf_host_monitor #(
  parameter int unsigned SUPPLY_CYC  = 20,
  parameter int unsigned POWERUP_CYC = 200
) (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       req_valid,
  input wire logic       req_ready,
  input wire logic [7:0] req_cmd,
  input wire logic       req_quad_link,
  input wire logic       req_cont_read,
  input wire logic       done,
  input wire logic       err,
  input wire logic       cont_mode,
  input wire logic       write_allowed,
  input wire logic       sclk,
  input wire logic       cs_n
);
  logic [31:0] age_q;
  logic        slow_q;
  wire         take = req_valid && req_ready;
  // Age counts from the pin release, two edges ahead of the design's copy
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      age_q  <= '0;
      slow_q <= 1'b0;
    end else begin
      age_q  <= age_q + 32'(age_q != '1);
      slow_q <= done ? 1'b0 : ((take && req_cmd == 8'h03) ? 1'b1 : slow_q);
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_sel_wait; !cs_n |-> age_q >= SUPPLY_CYC; endproperty
  a_sel_wait: assert property (p_sel_wait) else $error("select too early");
  property p_wr_wait; write_allowed |-> age_q >= POWERUP_CYC; endproperty
  a_wr_wait: assert property (p_wr_wait) else $error("writes allowed too early");
  property p_early_refuse; take && !write_allowed && req_cmd inside {8'h01, 8'h02, 8'h38,
    8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7, 8'h2F} |-> ##[1:2] (done && err); endproperty
  a_early_refuse: assert property (p_early_refuse) else $error("early write not refused");
  property p_quad_refuse; take && req_quad_link && req_cmd == 8'h03 |-> ##[1:2] (done && err);
  endproperty
  a_quad_refuse: assert property (p_quad_refuse) else $error("quad plain read taken");
  property p_clk_high; $rose(sclk) |-> sclk [*2]; endproperty
  a_clk_high: assert property (p_clk_high) else $error("link clock high too short");
  property p_slow_high; slow_q && $rose(sclk) |-> sclk [*4]; endproperty
  a_slow_high: assert property (p_slow_high) else $error("plain read clock too fast");
  property p_enter; take && req_cmd == 8'hEB && req_cont_read |-> ##[1:1000] (done && cont_mode);
  endproperty
  a_enter: assert property (p_enter) else $error("continuous read not entered");
  property p_leave; take && req_cmd == 8'hEB && !req_cont_read |-> ##[1:1000] (done && !cont_mode);
  endproperty
  a_leave: assert property (p_leave) else $error("continuous read not left");
endmodule
bind sqf_host sqf_host_monitor #(.SUPPLY_CYC(SUPPLY_CYC), .POWERUP_CYC(POWERUP_CYC))
  u_sqf_host_monitor (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
  .req_cmd(req_cmd), .req_quad_link(req_quad_link), .req_cont_read(req_cont_read), .done(done),
  .err(err), .cont_mode(cont_mode), .write_allowed(write_allowed), .sclk(sclk), .cs_n(cs_n));
`default_nettype wire

// >>> dv/sqf_flash_model.sv
/* Behavioural flash decoding the single line link.
   Assumes mode 0 clocking; a released output reads as its pull-up. */
`timescale 1ns/100ps
`default_nettype none
module sqf_flash_model #(
  parameter logic [7:0] MAKER_CODE = 8'h5C, // Arbitrary value
  parameter logic [7:0] PART_CODE  = 8'h3A, // Arbitrary value
  parameter logic [7:0] SIGNATURE  = 8'h17  // Arbitrary value
) (
  input  wire logic sclk,
  input  wire logic cs_n,
  input  wire logic si,
  output var  logic so,
  output var  logic so_en
);
  logic [31:0] ad, sh;
  logic [7:0]  op;
  logic        wel = 1'b0;
  int          n;
  int          busy = 0;
  assign so = sh[31];
  initial so_en = 1'b0;
  always @(negedge cs_n) begin
    n = 0;
    so_en = 1'b0;
  end
  always @(posedge sclk) if (!cs_n) begin
    ad = {ad[30:0], si};
    n++;
    op = (n == 8) ? ad[7:0] : op;
  end
  // Busy lasts two status polls, so the host must poll
  always @(posedge cs_n) begin
    so_en = 1'b0;
    wel = (n >= 8 && op inside {8'h06, 8'h04}) ? op == 8'h06 : wel;
    if (n >= 8 && op inside {8'h01, 8'h02, 8'h38, 8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7, 8'h2F}) begin
      busy = 2;
      wel = 1'b0;
    end else if (n >= 8 && op == 8'h05 && busy > 0)
      busy--;
  end
  always @(negedge sclk) if (!cs_n) begin
    if (n == 8 || n == 32) begin
      so_en = 1'b1;
      case ({n == 32, op})
        {1'b0, 8'h05}: sh = {6'h00, wel, busy != 0, 24'hFFFFFF};
        {1'b0, 8'h9F}: sh = {MAKER_CODE, PART_CODE, 16'hFFFF};
        {1'b1, 8'h90}: sh = {MAKER_CODE, PART_CODE, MAKER_CODE, 8'hFF} << {ad[0], 3'h0};
        {1'b1, 8'h03}: sh = '1;
        {1'b1, 8'hAB}: sh = {4{SIGNATURE}};
        default: so_en = 1'b0;
      endcase
    end else
      sh = {sh[30:0], 1'b1};
  end
endmodule
`default_nettype wire

// >>> dv/sqf_host_test.sv
/* Self-checking bench: flash host against the flash model.
   Assumes package, design, model and checker are compiled first. */
`timescale 1ns/100ps
`default_nettype none
module sqf_host_test;
  localparam logic [7:0] MAKER = 8'h5C; // Arbitrary value
  localparam logic [7:0] PART  = 8'h3A; // Arbitrary value
  localparam logic [7:0] SIG   = 8'h17; // Arbitrary value
  logic        clk, rst_n, req_valid, req_ready, req_quad_link, req_dummy_long, req_cont_read;
  logic        req_part_id_first, wr_valid, wr_ready, rd_valid, done, err, cont_mode;
  logic        write_allowed, sclk, cs_n, so, so_en;
  logic [7:0]  req_cmd, wr_data, rd_data, exp_q[$];
  logic [23:0] req_addr;
  logic [8:0]  req_len;
  logic [3:0]  io_o, io_oe_n, io_i;
  logic [7:0]  wr_cmds[9] = '{8'h01, 8'h02, 8'h38, 8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7, 8'h2F};
  logic [7:0]  quad_bad[5] = '{8'h9F, 8'h90, 8'h03, 8'hBB, 8'h38};
  int          err_total, checks_done, seed, k;
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Released lines pull up
  assign io_i = (io_o & ~io_oe_n) | ({2'b11, !so_en || so, 1'b1} & io_oe_n);
  sqf_host #(.SUPPLY_CYC(20), .POWERUP_CYC(400), .STATUS_TMO(2000), .PAGE_TMO(2000),
    .SECTOR_TMO(2000)) u_sqf_host (
    .clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready), .req_cmd(req_cmd),
    .req_addr(req_addr), .req_len(req_len), .req_quad_link(req_quad_link),
    .req_dummy_long(req_dummy_long), .req_cont_read(req_cont_read),
    .req_part_id_first(req_part_id_first), .wr_data(wr_data), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .rd_data(rd_data), .rd_valid(rd_valid), .done(done), .err(err),
    .cont_mode(cont_mode), .write_allowed(write_allowed), .sclk(sclk), .cs_n(cs_n),
    .io_o(io_o), .io_oe_n(io_oe_n), .io_i(io_i));
  sqf_flash_model u_sqf_flash_model (.sclk(sclk), .cs_n(cs_n), .si(io_i[0]), .so(so),
    .so_en(so_en));
  // Write data stalls at random; held only while offered with wr_ready high, redrawn while wr_ready is low
  always @(negedge clk) if (wr_ready !== 1'b1 || !wr_valid) begin
    wr_valid = 1'($random(seed));
    wr_data  = 8'($random(seed));
  end
  task automatic cmp(input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("Error at %0t ns: expected %h, got %h", $time, e, g);
    end
  endtask
  always @(negedge clk) if (rd_valid === 1'b1)
    cmp(exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX, rd_data);
  task automatic run(input logic [7:0] c, input logic [8:0] l, input logic ql, cr, pid, ee,
                     input logic [31:0] ex);
    int i;
    for (i = 0; i < l && !(c inside {8'h01, 8'h02, 8'h38}); i++)
      exp_q.push_back(ex[31 - 8 * i -: 8]);
    @(negedge clk);
    {req_cmd, req_len, req_quad_link, req_cont_read, req_part_id_first} = {c, l, ql, cr, pid};
    req_addr       = 24'($random(seed)) | 24'h100000;
    req_dummy_long = 1'($random(seed));
    req_valid      = 1'b1;
    for (i = 0; req_ready !== 1'b1 && i < 5000; i++) @(negedge clk);
    @(negedge clk);
    req_valid = 1'b0;
    for (i = 0; done !== 1'b1 && i < 20000; i++) @(negedge clk);
    cmp({7'h01, ee}, {6'h00, done, err});
    cmp(8'h00, 8'(exp_q.size()));
    $display("Test of command %h ended", c);
  endtask
  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Whole run needs about 8000 cycles
  initial begin
    #200000;
    err_total++;
    test_done;
  end
  initial begin
    seed = 27353;
    {req_valid, wr_valid, req_quad_link, req_dummy_long, req_cont_read, req_part_id_first} = '0;
    {req_cmd, req_addr, req_len, wr_data} = '0;
    rst_n = 1'b0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    run(8'h02, 1, 0, 0, 0, 1, 0);
    foreach (quad_bad[j]) run(quad_bad[j], 0, 1, 0, 0, 1, 0);
    for (k = 0; write_allowed !== 1'b1 && k < 1000; k++) @(negedge clk);
    run(8'h06, 0, 0, 0, 0, 0, 0);
    run(8'h05, 1, 0, 0, 0, 0, 32'h02000000);
    run(8'h04, 0, 1, 0, 0, 0, 0);
    run(8'h04, 0, 0, 0, 0, 0, 0);
    run(8'h05, 1, 0, 0, 0, 0, 0);
    run(8'h9F, 3, 0, 0, 0, 0, {MAKER, PART, 16'hFFFF});
    run(8'h90, 2, 0, 0, 0, 0, {MAKER, PART, 16'h0000});
    run(8'h90, 2, 0, 0, 1, 0, {PART, MAKER, 16'h0000});
    run(8'h03, 3, 0, 0, 0, 0, 32'hFFFFFF00);
    run(8'h0B, 1, 1, 0, 0, 0, 32'hFF000000);
    run(8'hAB, 2, 0, 0, 0, 0, {SIG, SIG, 16'h0000});
    foreach (wr_cmds[j]) run(wr_cmds[j], 9'(j < 3), 0, 0, 0, 0, 0);
    run(8'h05, 1, 0, 0, 0, 0, 0);
    run(8'hEB, 0, 0, 1, 0, 0, 0);
    run(8'hEB, 0, 1, 1, 0, 0, 0);
    run(8'h05, 1, 0, 0, 0, 0, 0);
    run(8'hEB, 0, 1, 0, 0, 0, 0);
    run(8'hB9, 0, 0, 0, 0, 0, 0);
    run(8'hAB, 0, 1, 0, 0, 0, 0);
    test_done;
  end
endmodule
`default_nettype wire
